/* design/srs_pkg.sv */
package srs_pkg;
    // word addresses on the serial register port
    localparam logic [7:0] ADDR_TEMP = 8'h2E;
    localparam logic [7:0] ADDR_PRES = 8'h30;
    localparam logic [7:0] ADDR_SYNC = 8'h32;
    localparam logic [7:0] ADDR_LIVE = 8'h36;
    localparam logic [7:0] ADDR_SER_LO = 8'h50;
    localparam logic [7:0] ADDR_SER_HI = 8'h52;
    // live status bit positions
    localparam int BIT_IDLE = 0;
    localparam int BIT_PRES_UP = 3;
    localparam int BIT_TEMP_UP = 4;
    localparam int BIT_SUPPLY = 7;
    localparam int BIT_CHECK = 8;
    localparam int BIT_SAT = 10;
    localparam int BIT_CRC = 11;
    localparam int BIT_PRES_MISS = 14;
    localparam int BIT_TEMP_MISS = 15;
    // bit classes
    localparam logic [15:0] EVENT_MASK = 16'hC998;
    localparam logic [15:0] STATUS_MASK = 16'h0401;
    localparam logic [15:0] STATUS_RST = 16'h0000;
    localparam logic [15:0] RESULT_RST = 16'h0000;
    // serial number, arbitrary value
    localparam logic [31:0] SERIAL_DEFAULT = 32'h0000_1234;
    typedef logic [15:0] srs_word_t;
endpackage

/* design/srs_link_if.sv */
`timescale 1ns/1ns
// register access request and answer between link side and core side
interface srs_link_if;
    logic rd_tgl;
    logic wr_tgl;
    logic [7:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic ack_tgl;
    modport link (output rd_tgl, output wr_tgl, output addr, output wdata,
        input rdata, input ack_tgl);
    modport core (input rd_tgl, input wr_tgl, input addr, input wdata,
        output rdata, output ack_tgl);
endinterface

/* design/srs_link_side.sv */
`timescale 1ns/1ns
// link-clock end: takes requests from the serial engine, hands them
// to the core domain by toggles, returns read data after the ack toggle
module srs_link_side
    import srs_pkg::*;
(
    // link clock domain
    input wire logic link_clk,
    input wire logic link_nrst,
    // serial engine request
    input wire logic req_rd,
    input wire logic req_wr,
    input wire logic [7:0] req_addr,
    input wire logic [15:0] req_wdata,
    output logic req_busy,
    output logic rsp_valid,
    output logic [15:0] rsp_rdata,
    // crossing
    srs_link_if.link lnk
);
    logic rd_tgl_r;
    logic wr_tgl_r;
    logic [7:0] addr_r;
    logic [15:0] wdata_r;
    logic ack_s1_r;
    logic ack_s2_r;
    logic ack_seen_r;
    logic busy_r;
    logic was_rd_r;
    logic valid_r;
    logic [15:0] rdata_r;

    assign lnk.rd_tgl = rd_tgl_r;
    assign lnk.wr_tgl = wr_tgl_r;
    assign lnk.addr = addr_r;
    assign lnk.wdata = wdata_r;
    assign req_busy = busy_r;
    assign rsp_valid = valid_r;
    assign rsp_rdata = rdata_r;

    always_ff @(posedge link_clk or negedge link_nrst) begin
        if (!link_nrst) begin
            ack_s1_r <= 1'b0;
            ack_s2_r <= 1'b0;
        end else begin
            ack_s1_r <= lnk.ack_tgl;
            ack_s2_r <= ack_s1_r;
        end
    end

    always_ff @(posedge link_clk or negedge link_nrst) begin
        if (!link_nrst) begin
            rd_tgl_r <= 1'b0;
            wr_tgl_r <= 1'b0;
            addr_r <= 8'h00;
            wdata_r <= 16'h0000;
            busy_r <= 1'b0;
            was_rd_r <= 1'b0;
            ack_seen_r <= 1'b0;
            valid_r <= 1'b0;
            rdata_r <= 16'h0000;
        end else begin
            valid_r <= 1'b0;
            if (busy_r && ack_s2_r != ack_seen_r) begin
                ack_seen_r <= ack_s2_r;
                busy_r <= 1'b0;
                valid_r <= was_rd_r;
                // data held stable by the core until next request
                if (was_rd_r) begin
                    rdata_r <= lnk.rdata;
                end
            end else if (!busy_r && (req_rd || req_wr)) begin
                addr_r <= req_addr;
                wdata_r <= req_wdata;
                was_rd_r <= req_rd;
                busy_r <= 1'b1;
                if (req_rd) begin
                    rd_tgl_r <= ~rd_tgl_r;
                end else begin
                    wr_tgl_r <= ~wr_tgl_r;
                end
            end
        end
    end
endmodule

/* design/srs_regs.sv */
`timescale 1ns/1ns
//Contract
//- new temperature result sets temperature-updated flag
//- new pressure result sets pressure-updated flag
//- results invalid until first measurement loaded
//- configuration CRC error blocks all result updates
//- snapshot bits 15:5,0 mirror live status
//- snapshot bits 4:3 captured on result read
//- burst from temperature gives temp, pressure, snapshot; no burst here, each access moves one word
//- bit 0 shows idle, live condition
//- pressure flag cleared by pressure result read
//- temperature flag cleared by temperature result read
//- latch supply, bridge check, comm CRC faults
//- bit 10 shows live saturation condition
//- pressure overwrite while flagged sets pressure missed
//- temperature overwrite while flagged sets temperature missed
//- events cleared by one-writes to live status, update flags also by result reads
//- all-ones write clears every event flag
//- status flags follow their hardware condition
//- read-only 32-bit serial number, two words
//- only live status accepts host writes
module srs_regs
    import srs_pkg::*;
(
    // core clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // link clock domain serial engine port
    input wire logic link_clk,
    input wire logic link_nrst,
    input wire logic req_rd,
    input wire logic req_wr,
    input wire logic [7:0] req_addr,
    input wire logic [15:0] req_wdata,
    output logic req_busy,
    output logic rsp_valid,
    output logic [15:0] rsp_rdata,
    // measurement engine, core clock
    input wire logic temp_load,
    input wire logic [15:0] temp_value,
    input wire logic pres_load,
    input wire logic [15:0] pres_value,
    input wire logic cfg_crc_error,
    // hardware conditions and fault events, core clock
    input wire logic chip_idle,
    input wire logic dsp_saturated,
    input wire logic bridge_supply_fault,
    input wire logic bridge_check_fault,
    input wire logic comm_crc_event,
    // observation
    output logic [15:0] live_status_q,
    output logic temp_valid,
    output logic pres_valid
);
    import srs_pkg::*;

    srs_link_if lnk ();

    srs_link_side u_link (
        .link_clk(link_clk),
        .link_nrst(link_nrst),
        .req_rd(req_rd),
        .req_wr(req_wr),
        .req_addr(req_addr),
        .req_wdata(req_wdata),
        .req_busy(req_busy),
        .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata),
        .lnk(lnk)
    );

    // toggle synchronisers
    logic rd_s1_r;
    logic rd_s2_r;
    logic rd_s3_r;
    logic wr_s1_r;
    logic wr_s2_r;
    logic wr_s3_r;
    logic ack_tgl_r;
    logic [15:0] rdata_r;
    logic [15:0] temp_r;
    logic [15:0] pres_r;
    logic [15:0] event_r;
    logic [15:0] cond_r;
    logic [4:3] snap_r;
    logic temp_valid_r;
    logic pres_valid_r;
    logic [15:0] live_q_r;
    logic rd_pulse;
    logic wr_pulse;
    logic temp_upd;
    logic pres_upd;
    logic rd_temp;
    logic rd_pres;
    logic wr_live;
    logic [15:0] live_view;
    logic [15:0] set_vec;
    logic [15:0] clr_vec;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rd_s1_r <= 1'b0;
            rd_s2_r <= 1'b0;
            rd_s3_r <= 1'b0;
            wr_s1_r <= 1'b0;
            wr_s2_r <= 1'b0;
            wr_s3_r <= 1'b0;
        end else begin
            rd_s1_r <= lnk.rd_tgl;
            rd_s2_r <= rd_s1_r;
            rd_s3_r <= rd_s2_r;
            wr_s1_r <= lnk.wr_tgl;
            wr_s2_r <= wr_s1_r;
            wr_s3_r <= wr_s2_r;
        end
    end

    assign rd_pulse = rd_s2_r ^ rd_s3_r;
    assign wr_pulse = wr_s2_r ^ wr_s3_r;
    assign rd_temp = rd_pulse && lnk.addr == ADDR_TEMP;
    assign rd_pres = rd_pulse && lnk.addr == ADDR_PRES;
    assign wr_live = wr_pulse && lnk.addr == ADDR_LIVE;
    assign temp_upd = temp_load && !cfg_crc_error;
    assign pres_upd = pres_load && !cfg_crc_error;
    assign live_view = (event_r & EVENT_MASK) | (cond_r & STATUS_MASK);
    assign lnk.rdata = rdata_r;
    assign lnk.ack_tgl = ack_tgl_r;
    assign live_status_q = live_q_r;
    assign temp_valid = temp_valid_r;
    assign pres_valid = pres_valid_r;

    // result registers
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            temp_r <= RESULT_RST;
            pres_r <= RESULT_RST;
            temp_valid_r <= 1'b0;
            pres_valid_r <= 1'b0;
        end else begin
            if (temp_upd) begin
                temp_r <= temp_value;
                temp_valid_r <= 1'b1;
            end
            if (pres_upd) begin
                pres_r <= pres_value;
                pres_valid_r <= 1'b1;
            end
        end
    end

    // event flags: set wins over clear
    always_comb begin
        set_vec = 16'h0000;
        set_vec[BIT_TEMP_UP] = temp_upd;
        set_vec[BIT_PRES_UP] = pres_upd;
        set_vec[BIT_TEMP_MISS] = temp_upd && event_r[BIT_TEMP_UP];
        set_vec[BIT_PRES_MISS] = pres_upd && event_r[BIT_PRES_UP];
        set_vec[BIT_SUPPLY] = bridge_supply_fault;
        set_vec[BIT_CHECK] = bridge_check_fault;
        set_vec[BIT_CRC] = comm_crc_event;
        clr_vec = wr_live ? lnk.wdata : 16'h0000;
        clr_vec[BIT_TEMP_UP] = clr_vec[BIT_TEMP_UP] | rd_temp;
        clr_vec[BIT_PRES_UP] = clr_vec[BIT_PRES_UP] | rd_pres;
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            event_r <= STATUS_RST;
        end else begin
            event_r <= (event_r & ~clr_vec | set_vec) & EVENT_MASK;
        end
    end

    // live conditions, not latched
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cond_r <= STATUS_RST;
        end else begin
            cond_r <= 16'h0000;
            cond_r[BIT_IDLE] <= chip_idle;
            cond_r[BIT_SAT] <= dsp_saturated;
        end
    end

    // snapshot update flags captured at result read
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            snap_r <= 2'b00;
        end else begin
            if (rd_temp) begin
                snap_r[BIT_TEMP_UP] <= event_r[BIT_TEMP_UP];
            end
            if (rd_pres) begin
                snap_r[BIT_PRES_UP] <= event_r[BIT_PRES_UP];
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            live_q_r <= STATUS_RST;
        end else begin
            live_q_r <= live_view;
        end
    end

    // read mux and answer; data set in the same cycle the ack toggles
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_r <= 16'h0000;
            ack_tgl_r <= 1'b0;
        end else begin
            if (rd_pulse) begin
                ack_tgl_r <= ~ack_tgl_r;
                unique case (lnk.addr)
                    ADDR_TEMP: rdata_r <= temp_r;
                    ADDR_PRES: rdata_r <= pres_r;
                    ADDR_SYNC: rdata_r <= {live_view[15:5],
                        snap_r[4],
                        snap_r[3], 2'b00, live_view[0]};
                    ADDR_LIVE: rdata_r <= live_view;
                    ADDR_SER_LO: rdata_r <= SERIAL_DEFAULT[15:0];
                    ADDR_SER_HI: rdata_r <= SERIAL_DEFAULT[31:16];
                    default: rdata_r <= 16'h0000;
                endcase
            end else if (wr_pulse) begin
                ack_tgl_r <= ~ack_tgl_r;
            end
        end
    end

    // checks
    property p_temp_up;
        @(posedge core_clk) disable iff (!nrst)
        temp_upd |=> event_r[BIT_TEMP_UP];
    endproperty
    a_temp_up: assert property (p_temp_up)
        else $error("temperature flag not set");

    property p_pres_up;
        @(posedge core_clk) disable iff (!nrst)
        pres_upd |=> event_r[BIT_PRES_UP];
    endproperty
    a_pres_up: assert property (p_pres_up)
        else $error("pressure flag not set");

    property p_crc_block;
        @(posedge core_clk) disable iff (!nrst)
        cfg_crc_error |=> $stable(temp_r) && $stable(pres_r);
    endproperty
    a_crc_block: assert property (p_crc_block)
        else $error("result changed under CRC error");

    property p_miss;
        @(posedge core_clk) disable iff (!nrst)
        temp_upd && event_r[BIT_TEMP_UP] |=> event_r[BIT_TEMP_MISS];
    endproperty
    a_miss: assert property (p_miss)
        else $error("temperature missed not set");

    property p_pmiss;
        @(posedge core_clk) disable iff (!nrst)
        pres_upd && event_r[BIT_PRES_UP] |=> event_r[BIT_PRES_MISS];
    endproperty
    a_pmiss: assert property (p_pmiss)
        else $error("pressure missed not set");

    property p_rd_clr;
        @(posedge core_clk) disable iff (!nrst)
        rd_temp && !temp_upd |=> !event_r[BIT_TEMP_UP];
    endproperty
    a_rd_clr: assert property (p_rd_clr)
        else $error("temperature flag not cleared on read");

    property p_snap;
        @(posedge core_clk) disable iff (!nrst)
        rd_pres |=> snap_r[BIT_PRES_UP] == $past(event_r[BIT_PRES_UP]);
    endproperty
    a_snap: assert property (p_snap)
        else $error("snapshot pressure bit wrong");

    property p_idle;
        @(posedge core_clk) disable iff (!nrst)
        ##1 live_view[BIT_IDLE] == $past(chip_idle);
    endproperty
    a_idle: assert property (p_idle)
        else $error("idle bit not live");

    property p_resv;
        @(posedge core_clk) disable iff (!nrst)
        (live_view & ~(EVENT_MASK | STATUS_MASK)) == 16'h0000;
    endproperty
    a_resv: assert property (p_resv)
        else $error("reserved bit set");

    property p_pclr;
        @(posedge core_clk) disable iff (!nrst)
        rd_pres && !pres_upd |=> !event_r[BIT_PRES_UP];
    endproperty
    a_pclr: assert property (p_pclr)
        else $error("pressure flag not cleared on read");

    property p_supply;
        @(posedge core_clk) disable iff (!nrst)
        bridge_supply_fault |=> event_r[BIT_SUPPLY];
    endproperty
    a_supply: assert property (p_supply)
        else $error("supply fault not latched");

    property p_comm;
        @(posedge core_clk) disable iff (!nrst)
        comm_crc_event |=> event_r[BIT_CRC];
    endproperty
    a_comm: assert property (p_comm)
        else $error("link check fault not latched");

    property p_sat;
        @(posedge core_clk) disable iff (!nrst)
        ##1 live_view[BIT_SAT] == $past(dsp_saturated);
    endproperty
    a_sat: assert property (p_sat)
        else $error("saturation bit not live");

    property p_keep;
        @(posedge core_clk) disable iff (!nrst)
        event_r[BIT_CRC] && !(wr_live && lnk.wdata[BIT_CRC])
            |=> event_r[BIT_CRC];
    endproperty
    a_keep: assert property (p_keep)
        else $error("event flag lost without clear");

    property p_all_clr;
        @(posedge core_clk) disable iff (!nrst)
        wr_live && lnk.wdata == 16'hFFFF && set_vec == 16'h0000
            |=> event_r == 16'h0000;
    endproperty
    a_all_clr: assert property (p_all_clr)
        else $error("all-ones write left an event");

    property p_ro;
        @(posedge core_clk) disable iff (!nrst)
        !temp_upd && !pres_upd |=> $stable(temp_r) && $stable(pres_r);
    endproperty
    a_ro: assert property (p_ro)
        else $error("result changed without a load");
endmodule

/* sim/srs_host_model.sv */
`timescale 1ns/1ns
// serial engine stand-in: one word access outstanding at a time
module srs_host_model
    import srs_pkg::*;
(
    // link clock domain
    input wire logic link_clk,
    input wire logic link_nrst,
    // request port
    output logic req_rd,
    output logic req_wr,
    output logic [7:0] req_addr,
    output logic [15:0] req_wdata,
    input wire logic req_busy,
    input wire logic rsp_valid,
    input wire logic [15:0] rsp_rdata
);
    int gap = 0;
    bit lost = 0;
    initial begin
        req_rd = 1'b0;
        req_wr = 1'b0;
        req_addr = 8'h00;
        req_wdata = 16'h0000;
    end
    // request pulse, then wait for busy to drop
    task automatic access(input logic wr, input logic [7:0] a,
            input logic [15:0] wd, output logic [15:0] rd);
        int n;
        repeat (gap + 1) @(posedge link_clk);
        req_rd <= !wr;
        req_wr <= wr;
        req_addr <= a;
        req_wdata <= wd;
        @(posedge link_clk);
        req_rd <= 1'b0;
        req_wr <= 1'b0;
        for (n = 0; n < 40; n++) begin
            @(posedge link_clk);
            if (!req_busy) break;
        end
        if (n == 40 || (!wr && !rsp_valid)) lost = 1'b1;
        rd = rsp_rdata;
        // stale write data is not left on the lines
        req_wdata <= ~wd;
    endtask
    // results trusted only once both update flags were seen
    task automatic wait_ready(output bit ok);
        logic [15:0] s;
        logic [1:0] seen;
        seen = 2'b00;
        for (int i = 0; i < 50 && seen != 2'b11; i++) begin
            access(1'b0, ADDR_LIVE, 16'h0000, s);
            seen = seen | s[4:3];
        end
        ok = (seen == 2'b11);
    endtask
endmodule

/* sim/test_sensor_result_status_regs.sv */
`timescale 1ns/1ns
module test_sensor_result_status_regs;
    import srs_pkg::*;
    typedef struct {
        logic [4:0] ev;
        logic [15:0] exp;
    } srs_row_s;
    logic core_clk, nrst, link_clk, link_nrst;
    logic req_rd, req_wr, req_busy, rsp_valid;
    logic [7:0] req_addr;
    logic [15:0] req_wdata, rsp_rdata, live_status_q, rd;
    logic temp_load, pres_load, cfg_crc_error, chip_idle, dsp_saturated;
    logic bridge_supply_fault, bridge_check_fault, comm_crc_event;
    logic [15:0] temp_value, pres_value;
    logic temp_valid, pres_valid;
    logic [4:0] ev_drv;
    int errors = 0;
    int check_count = 0;
    int cycles = 0;
    bit ok;
    srs_row_s rows [5];
    assign {temp_load, pres_load, bridge_supply_fault, bridge_check_fault,
        comm_crc_event} = ev_drv;

    srs_regs dut_u (.core_clk, .nrst, .link_clk, .link_nrst, .req_rd,
        .req_wr, .req_addr, .req_wdata, .req_busy, .rsp_valid, .rsp_rdata,
        .temp_load, .temp_value, .pres_load, .pres_value, .cfg_crc_error,
        .chip_idle, .dsp_saturated, .bridge_supply_fault,
        .bridge_check_fault, .comm_crc_event, .live_status_q, .temp_valid,
        .pres_valid);
    srs_host_model host_u (.link_clk, .link_nrst, .req_rd, .req_wr,
        .req_addr, .req_wdata, .req_busy, .rsp_valid, .rsp_rdata);

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    initial begin
        link_clk = 1'b0;
        #17;
        forever begin
            #62 link_clk = 1'b1;
            #63 link_clk = 1'b0;
        end
    end

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors = errors + 1;
            tally_and_finish();
        end
    end
    task automatic check(input string name, input logic [15:0] got,
            input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s exp %h got %h", name, exp, got);
        end
    endtask
    task automatic rd_w(input logic [7:0] a);
        host_u.access(1'b0, a, 16'h0000, rd);
    endtask
    task automatic wr_w(input logic [7:0] a, input logic [15:0] d);
        host_u.access(1'b1, a, d, rd);
    endtask
    // inputs: {temp, pres, supply, check, comm}
    task automatic pulse(input logic [4:0] ev);
        @(posedge core_clk);
        ev_drv <= ev;
        @(posedge core_clk);
        ev_drv <= 5'h00;
        repeat (4) @(posedge core_clk);
    endtask

    initial begin
        nrst = 1'b0;
        link_nrst = 1'b0;
        ev_drv = 5'h00;
        cfg_crc_error = 1'b0;
        chip_idle = 1'b0;
        dsp_saturated = 1'b0;
        temp_value = 16'h5A5A;
        pres_value = 16'h3C3C;
        rows = '{'{5'h04, 16'h0080}, '{5'h02, 16'h0100},
            '{5'h01, 16'h0800}, '{5'h10, 16'h0010}, '{5'h08, 16'h0008}};
        repeat (20) @(posedge core_clk);
        nrst <= 1'b1;
        link_nrst <= 1'b1;
        repeat (2) @(posedge link_clk);
        check("valid", {14'h0, temp_valid, pres_valid}, 16'h0000);
        rd_w(ADDR_SYNC);
        check("sync rst", rd, STATUS_RST);
        rd_w(ADDR_SER_LO);
        check("ser lo", rd, SERIAL_DEFAULT[15:0]);
        rd_w(ADDR_SER_HI);
        check("ser hi", rd, SERIAL_DEFAULT[31:16]);
        wr_w(ADDR_SER_LO, 16'hFFFF);
        rd_w(ADDR_SER_LO);
        check("ser ro", rd, SERIAL_DEFAULT[15:0]);
        rd_w(8'h40);
        check("unmapped", rd, 16'h0000);
        // loads while the configuration check failed
        @(posedge core_clk);
        cfg_crc_error <= 1'b1;
        pulse(5'h18);
        check("crc vld", {14'h0, temp_valid, pres_valid}, 16'h0000);
        check("crc live", live_status_q, 16'h0000);
        rd_w(ADDR_TEMP);
        check("crc temp", rd, RESULT_RST);
        @(posedge core_clk);
        cfg_crc_error <= 1'b0;
        foreach (rows[i]) begin
            pulse(rows[i].ev);
            check("live", live_status_q, rows[i].exp);
            rd_w(ADDR_LIVE);
            check("live rd", rd, rows[i].exp);
            wr_w(ADDR_LIVE, rows[i].exp);
            rd_w(ADDR_LIVE);
            check("cleared", rd, 16'h0000);
        end
        check("valid", {14'h0, temp_valid, pres_valid}, 16'h0003);
        // overwrite unread results
        @(posedge core_clk);
        temp_value <= 16'hA1A1;
        pres_value <= 16'hB2B2;
        pulse(5'h18);
        host_u.wait_ready(ok);
        check("ready", {15'h0, ok}, 16'h0001);
        @(posedge core_clk);
        temp_value <= 16'hC3C3;
        pres_value <= 16'hD4D4;
        chip_idle <= 1'b1;
        dsp_saturated <= 1'b1;
        pulse(5'h18);
        rd_w(ADDR_TEMP);
        check("temp", rd, 16'hC3C3);
        rd_w(ADDR_PRES);
        check("pres", rd, 16'hD4D4);
        rd_w(ADDR_SYNC);
        check("sync", rd, 16'hC419);
        rd_w(ADDR_LIVE);
        check("missed", rd, 16'hC401);
        wr_w(ADDR_SYNC, 16'hFFFF);
        wr_w(ADDR_TEMP, 16'h0000);
        rd_w(ADDR_LIVE);
        check("sync wr", rd, 16'hC401);
        rd_w(ADDR_TEMP);
        check("temp ro", rd, 16'hC3C3);
        wr_w(ADDR_LIVE, 16'h8000);
        rd_w(ADDR_LIVE);
        check("one clr", rd, 16'h4401);
        wr_w(ADDR_LIVE, 16'hFFFF);
        rd_w(ADDR_LIVE);
        check("all ones", rd, 16'h0401);
        @(posedge core_clk);
        chip_idle <= 1'b0;
        dsp_saturated <= 1'b0;
        host_u.gap = 3;
        rd_w(ADDR_TEMP);
        rd_w(ADDR_PRES);
        rd_w(ADDR_SYNC);
        check("sync idle", rd, 16'h0000);
        // second reset with fault flags latched
        pulse(5'h07);
        check("faults", live_status_q, 16'h0980);
        @(posedge core_clk);
        nrst <= 1'b0;
        link_nrst <= 1'b0;
        repeat (8) @(posedge core_clk);
        check("rst live", live_status_q, STATUS_RST);
        check("rst vld", {14'h0, temp_valid, pres_valid}, 16'h0000);
        nrst <= 1'b1;
        link_nrst <= 1'b1;
        repeat (2) @(posedge link_clk);
        rd_w(ADDR_SER_LO);
        check("rst ser", rd, SERIAL_DEFAULT[15:0]);
        rd_w(ADDR_LIVE);
        check("rst rd", rd, STATUS_RST);
        check("host", {15'h0, host_u.lost}, 16'h0000);
        tally_and_finish();
    end
endmodule
